// ===== bench/mocc_top_tb.sv
// self-checking bench for the monitor offset and conversion control block
`timescale 1ns/1ps
`default_nettype none
`include "mocc_map.svh"
module mocc_top_tb;
  // short slot keeps the run brief; must stay >= 16
  localparam int SLOT = 32;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, single_channel_mode_done;
  logic awready, wready, bvalid, arready, rvalid, single_channel_mode_start, averaging_on, result_valid;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, attenuator_bypass_off;
  logic [1:0] bresp, rresp;
  logic [2:0] tacho_four_wire, single_channel_mode_channel, result_chan;
  logic [7:0] single_channel_mode_raw, result;
  int errors = 0;
  int n_compared = 0;
  int n;
  logic [2:0] prev;
  // offset cases: channel code, config five value, raw sample, expected result
  logic [2:0] oc_ch [6] = '{3'h6, 3'h7, 3'h6, 3'h7, 3'h5, 3'h6};
  logic [7:0] oc_c5 [6] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h02, 8'h02};
  logic [7:0] oc_raw [6] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'hfe};
  logic [7:0] oc_exp [6] = '{8'h45, 8'h3e, 8'h42, 8'h3f, 8'h40, 8'h03};

  always #5 aclk = ~aclk;

  mocc_top #(.SLOT_CYCLES(SLOT)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .tacho_four_wire(tacho_four_wire), .single_channel_mode_start(single_channel_mode_start), .single_channel_mode_channel(single_channel_mode_channel),
    .averaging_on(averaging_on), .attenuator_bypass_off(attenuator_bypass_off), .single_channel_mode_done(single_channel_mode_done),
    .single_channel_mode_raw(single_channel_mode_raw), .result(result), .result_chan(result_chan),
    .result_valid(result_valid)
  );

  task automatic end_of_test();
    $display("comparisons %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic fail_wait(input string what);
    errors++;
    $display("[ERR] %s expected handshake seen timeout", what);
    end_of_test();
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st,
    input logic [1:0] exp);
    logic a, w, b;
    logic [1:0] r;
    b = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= st;
    bready <= 1'b1;
    for (int k = 0; k < 100 && !b; k++)
    begin
      @(negedge aclk);
      a = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      if (b)
        bready <= 1'b0;
    end
    if (!b)
      fail_wait("write response");
    chk_resp("bresp", exp, r);
  endtask

  task automatic axi_read(input logic [7:0] idx, input logic [31:0] exp_d,
    input logic [1:0] exp);
    logic a, b;
    logic [1:0] r;
    logic [31:0] d;
    b = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    rready <= 1'b1;
    for (int k = 0; k < 100 && !b; k++)
    begin
      @(negedge aclk);
      a = arvalid & arready;
      b = rvalid;
      r = rresp;
      d = rdata;
      @(posedge aclk);
      if (a)
        arvalid <= 1'b0;
      if (b)
        rready <= 1'b0;
    end
    if (!b)
      fail_wait("read response");
    chk_resp("rresp", exp, r);
    chk_val("rdata", exp_d, d);
  endtask

  // counts cycles up to and including the next start pulse
  task automatic wait_start(output int c);
    c = 0;
    do
    begin
      @(negedge aclk);
      c++;
      if (c > 4 * SLOT)
        fail_wait("single_channel_mode_start");
    end while (single_channel_mode_start !== 1'b1);
  endtask

  task automatic single_channel_mode_check(input logic [7:0] raw, input logic [7:0] exp, input logic [2:0] ch);
    @(posedge aclk);
    single_channel_mode_done <= 1'b1;
    single_channel_mode_raw <= raw;
    @(posedge aclk);
    single_channel_mode_done <= 1'b0;
    @(negedge aclk);
    chk_val("result_valid", 32'h1, {31'h0, result_valid});
    chk_val("result", {24'h0, exp}, {24'h0, result});
    chk_val("result_chan", {29'h0, ch}, {29'h0, result_chan});
    @(negedge aclk);
    chk_val("result_valid pulse", 32'h0, {31'h0, result_valid});
  endtask

  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, single_channel_mode_done} = 6'h00;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    tacho_four_wire = 3'h0;
    single_channel_mode_raw = 8'h00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`MOCC_IDX_LOFS, 32'h0, `MOCC_RESP_OKAY);
    axi_read(`MOCC_IDX_R2OFS, 32'h0, `MOCC_RESP_OKAY);
    axi_read(`MOCC_IDX_CFG2, 32'h0, `MOCC_RESP_OKAY);
    chk_val("averaging_on", 32'h1, {31'h0, averaging_on});
    axi_read(8'h00, 32'h0, `MOCC_RESP_SLVERR);
    axi_write(8'h00, 8'h55, 4'h1, `MOCC_RESP_SLVERR);
    axi_write(`MOCC_IDX_LOFS, 8'h05, 4'h1, `MOCC_RESP_OKAY);
    axi_write(`MOCC_IDX_LOFS, 8'h77, 4'h0, `MOCC_RESP_OKAY);
    axi_read(`MOCC_IDX_LOFS, 32'h05, `MOCC_RESP_OKAY);
    axi_write(`MOCC_IDX_R2OFS, 8'hfe, 4'h1, `MOCC_RESP_OKAY);
    axi_read(`MOCC_IDX_R2OFS, 32'hfe, `MOCC_RESP_OKAY);
    // flag bits are written as ones but must not stick; top bit kept at zero
    tacho_four_wire <= 3'b101;
    axi_write(`MOCC_IDX_CFG2, 8'h0e, 4'h1, `MOCC_RESP_OKAY);
    axi_read(`MOCC_IDX_CFG2, 32'h00, `MOCC_RESP_OKAY);
    axi_write(`MOCC_IDX_CFG2, 8'h01, 4'h1, `MOCC_RESP_OKAY);
    axi_read(`MOCC_IDX_CFG2, 32'h0b, `MOCC_RESP_OKAY);
    tacho_four_wire <= 3'b010;
    axi_read(`MOCC_IDX_CFG2, 32'h05, `MOCC_RESP_OKAY);
    axi_write(`MOCC_IDX_CFG2, 8'h30, 4'h1, `MOCC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val("averaging_on", 32'h0, {31'h0, averaging_on});
    chk_val("attenuator_bypass_off", 32'hf, {28'h0, attenuator_bypass_off});
    axi_write(`MOCC_IDX_CFG2, 8'h10, 4'h1, `MOCC_RESP_OKAY);
    axi_write(`MOCC_IDX_CFG4, 8'ha0, 4'h1, `MOCC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val("attenuator_bypass_off", 32'ha, {28'h0, attenuator_bypass_off});
    wait_start(n);
    wait_start(n);
    chk_val("fast slot", SLOT / `MOCC_AVG_FACTOR, n);
    axi_write(`MOCC_IDX_CFG2, 8'h50, 4'h1, `MOCC_RESP_OKAY);
    for (int c = 0; c < 8; c++)
    begin
      axi_write(`MOCC_IDX_TMIN1, {c[2:0], 5'h00}, 4'h1, `MOCC_RESP_OKAY);
      wait_start(n);
      for (int j = 0; j < 2; j++)
      begin
        wait_start(n);
        chk_val("single channel", c, {29'h0, single_channel_mode_channel});
      end
    end
    for (int i = 0; i < 6; i++)
    begin
      axi_write(`MOCC_IDX_CFG5, oc_c5[i], 4'h1, `MOCC_RESP_OKAY);
      axi_write(`MOCC_IDX_TMIN1, {oc_ch[i], 5'h00}, 4'h1, `MOCC_RESP_OKAY);
      wait_start(n);
      wait_start(n);
      single_channel_mode_check(oc_raw[i], oc_exp[i], oc_ch[i]);
    end
    axi_write(`MOCC_IDX_CFG2, 8'h10, 4'h1, `MOCC_RESP_OKAY);
    wait_start(n);
    wait_start(n);
    prev = single_channel_mode_channel;
    for (int i = 0; i < 9; i++)
    begin
      wait_start(n);
      chk_val("sequence channel", {29'h0, prev + 3'h1}, {29'h0, single_channel_mode_channel});
      prev = single_channel_mode_channel;
    end
    axi_write(`MOCC_IDX_CFG2, 8'h00, 4'h1, `MOCC_RESP_OKAY);
    wait_start(n);
    wait_start(n);
    chk_val("averaged slot", SLOT, n);
    axi_write(`MOCC_IDX_CFG1, 8'h02, 4'h1, `MOCC_RESP_OKAY);
    axi_write(`MOCC_IDX_LOFS, 8'h33, 4'h1, `MOCC_RESP_OKAY);
    axi_write(`MOCC_IDX_R2OFS, 8'h11, 4'h1, `MOCC_RESP_OKAY);
    axi_read(`MOCC_IDX_LOFS, 32'h05, `MOCC_RESP_OKAY);
    axi_read(`MOCC_IDX_R2OFS, 32'hfe, `MOCC_RESP_OKAY);
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== hw/mocc_map.svh
// register indices, field positions, reset values and timing counts
// What this block does
// - Local temperature results get the local offset added automatically.
// - Remote two temperature results get the remote two offset added automatically.
// - Range and resolution of both offsets follow the range bit of config five.
// - While the lock bit is set, offset registers ignore every write.
// - With detect enabled, config two bits three to one show fan presence.
// - Three read-only flags report a four-wire fan on tacho one to three.
// - Averaging disable stops averaging; each channel converts sixteen times faster.
// - Attenuator bypass removes attenuators from 2.5 V, core, 5 V and 12 V.
// - Config four bits seven to four remove attenuators per channel.
// - Single-channel mode converts one selected input continuously.
// - Single-channel input comes from tacho one minimum bits seven to five.
// - After reset config two and both offsets hold zero.
`ifndef MOCC_MAP_SVH
`define MOCC_MAP_SVH
`define MOCC_IDX_CFG1 8'h40
`define MOCC_IDX_TMIN1 8'h55
`define MOCC_IDX_LOFS 8'h71
`define MOCC_IDX_R2OFS 8'h72
`define MOCC_IDX_CFG2 8'h73
`define MOCC_IDX_CFG5 8'h7c
`define MOCC_IDX_CFG4 8'h7d
`define MOCC_RST_ZERO 8'h00
`define MOCC_CFG2_RW_MASK 8'h71
`define MOCC_LOCK_BIT 1
`define MOCC_RANGE_BIT 1
`define MOCC_FDET_BIT 0
`define MOCC_AVG_BIT 4
`define MOCC_ATTENUATOR_BYPASS_BIT 5
`define MOCC_SINGLE_BIT 6
`define MOCC_CHSEL_LSB 5
`define MOCC_SLOT_CYCLES 1024
`define MOCC_AVG_FACTOR 16
`define MOCC_RESP_OKAY 2'h0
`define MOCC_RESP_SLVERR 2'h2
`endif

// ===== hw/mocc_pkg.sv
// types shared by the monitor config block
package mocc_pkg;
  typedef enum logic [2:0] {
    CH_2V5 = 3'h0,
    CH_CORE = 3'h1,
    CH_3V3 = 3'h2,
    CH_5V = 3'h3,
    CH_12V = 3'h4,
    CH_REM1 = 3'h5,
    CH_LOCAL = 3'h6,
    CH_REM2 = 3'h7
  } mocc_chan_t;
  typedef enum {WR_IDLE, WR_RESP} mocc_wr_st_t;
endpackage

// ===== hw/mocc_top.sv
// monitor offset, fan presence and conversion control behind axi4-lite
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mocc_map.svh"
module mocc_top #(
  parameter int SLOT_CYCLES = `MOCC_SLOT_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [9:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [9:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // fan presence sense
  input wire logic [2:0] tacho_four_wire,
  // converter control
  output logic single_channel_mode_start,
  output logic [2:0] single_channel_mode_channel,
  output logic averaging_on,
  output logic [3:0] attenuator_bypass_off,
  // converter results
  input wire logic single_channel_mode_done,
  input wire logic [7:0] single_channel_mode_raw,
  output logic [7:0] result,
  output logic [2:0] result_chan,
  output logic result_valid
);
  localparam logic [15:0] SLOW_LEN = 16'(SLOT_CYCLES);
  localparam logic [15:0] FAST_LEN = 16'(SLOT_CYCLES / `MOCC_AVG_FACTOR);
  logic awready_r, aw_held_r, wready_r, w_held_r, bvalid_r;
  logic arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] widx_r, wdat_r, rdat_r;
  logic wlane_r;
  mocc_pkg::mocc_wr_st_t wr_st_r;
  logic [7:0] cfg1_r, tmin1_r, lofs_r, r2ofs_r, cfg2_r, cfg5_r, cfg4_r;
  logic [2:0] flags_r;
  logic [15:0] slot_cnt_r, slot_len_r;
  logic single_channel_mode_start_r, avg_on_r, res_valid_r;
  logic [2:0] chan_r, res_chan_r;
  logic [3:0] attenuator_bypass_r;
  logic [7:0] res_r;
  logic [7:0] rd_word;
  logic rd_ok;
  default clocking guard_ck @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire wr_fire = (wr_st_r == mocc_pkg::WR_IDLE) && aw_held_r && w_held_r;
  wire we = wr_fire && wlane_r;
  wire w_cfg1 = widx_r == `MOCC_IDX_CFG1;
  wire w_tmin = widx_r == `MOCC_IDX_TMIN1;
  wire w_lofs = widx_r == `MOCC_IDX_LOFS;
  wire w_r2 = widx_r == `MOCC_IDX_R2OFS;
  wire w_cfg2 = widx_r == `MOCC_IDX_CFG2;
  wire w_cfg5 = widx_r == `MOCC_IDX_CFG5;
  wire w_cfg4 = widx_r == `MOCC_IDX_CFG4;
  wire w_map = w_cfg1 | w_tmin | w_lofs | w_r2 | w_cfg2 | w_cfg5 | w_cfg4;
  wire locked = cfg1_r[`MOCC_LOCK_BIT];
  // lock is sticky: once set only a reset clears it
  wire [7:0] lock_keep = {7'h00, locked} << `MOCC_LOCK_BIT;
  wire [7:0] cfg1_nxt = wdat_r | lock_keep;
  // reserved top bit never stored, so a careless host write cannot flip it
  wire [7:0] cfg2_nxt = wdat_r & `MOCC_CFG2_RW_MASK;
  wire [7:0] cfg2_view = {1'b0, cfg2_r[6:4], flags_r, cfg2_r[0]};
  wire avg_dis = cfg2_r[`MOCC_AVG_BIT];
  wire single = cfg2_r[`MOCC_SINGLE_BIT];
  wire [2:0] sel = tmin1_r[`MOCC_CHSEL_LSB +: 3];
  wire slot_end = slot_cnt_r == (slot_len_r - 16'h1);
  wire [15:0] len_nxt = avg_dis ? FAST_LEN : SLOW_LEN;
  wire [2:0] chan_nxt = single ? sel : chan_r + 3'h1;
  wire range_full = cfg5_r[`MOCC_RANGE_BIT];
  // half range keeps the sign and drops the half-degree bit
  wire [7:0] l_eff = range_full ? lofs_r : {lofs_r[7], lofs_r[7:1]};
  wire [7:0] r_eff = range_full ? r2ofs_r : {r2ofs_r[7], r2ofs_r[7:1]};
  wire is_loc = chan_r == mocc_pkg::CH_LOCAL;
  wire is_r2 = chan_r == mocc_pkg::CH_REM2;
  wire [7:0] ofs_sel = is_loc ? l_eff : (is_r2 ? r_eff : 8'h00);
  wire [7:0] corr = single_channel_mode_raw + ofs_sel;
  wire [3:0] attenuator_bypass_nxt = {4{cfg2_r[`MOCC_ATTENUATOR_BYPASS_BIT]}} | cfg4_r[7:4];
  // write address channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b0;
      widx_r <= 8'h00;
    end
    else if (awvalid && awready_r)
    begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b1;
      widx_r <= awaddr[9:2];
    end
    else if (wr_fire)
      aw_held_r <= 1'b0;
    else if (!aw_held_r && wr_st_r == mocc_pkg::WR_IDLE)
      awready_r <= 1'b1;
  end
  // write data channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_r <= 1'b0;
      w_held_r <= 1'b0;
      wdat_r <= 8'h00;
      wlane_r <= 1'b0;
    end
    else if (wvalid && wready_r)
    begin
      wready_r <= 1'b0;
      w_held_r <= 1'b1;
      wdat_r <= wdata[7:0];
      wlane_r <= wstrb[0];
    end
    else if (wr_fire)
      w_held_r <= 1'b0;
    else if (!w_held_r && wr_st_r == mocc_pkg::WR_IDLE)
      wready_r <= 1'b1;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_st_r <= mocc_pkg::WR_IDLE;
      bvalid_r <= 1'b0;
      bresp_r <= `MOCC_RESP_OKAY;
    end
    else
    begin
      case (wr_st_r)
        mocc_pkg::WR_IDLE:
          if (wr_fire)
          begin
            wr_st_r <= mocc_pkg::WR_RESP;
            bvalid_r <= 1'b1;
            bresp_r <= w_map ? `MOCC_RESP_OKAY : `MOCC_RESP_SLVERR;
          end
        mocc_pkg::WR_RESP:
          if (bready)
          begin
            wr_st_r <= mocc_pkg::WR_IDLE;
            bvalid_r <= 1'b0;
          end
      endcase
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg1_r <= `MOCC_RST_ZERO;
      tmin1_r <= `MOCC_RST_ZERO;
      lofs_r <= `MOCC_RST_ZERO;
      r2ofs_r <= `MOCC_RST_ZERO;
      cfg2_r <= `MOCC_RST_ZERO;
      cfg5_r <= `MOCC_RST_ZERO;
      cfg4_r <= `MOCC_RST_ZERO;
    end
    else if (we)
    begin
      if (w_cfg1)
        cfg1_r <= cfg1_nxt;
      if (w_tmin)
        tmin1_r <= wdat_r;
      if (w_lofs && !locked)
        lofs_r <= wdat_r;
      if (w_r2 && !locked)
        r2ofs_r <= wdat_r;
      if (w_cfg2)
        cfg2_r <= cfg2_nxt;
      if (w_cfg5)
        cfg5_r <= wdat_r;
      if (w_cfg4)
        cfg4_r <= wdat_r;
    end
  end
  // presence flags only report while detection is enabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_r <= 3'h0;
    else
      flags_r <= cfg2_r[`MOCC_FDET_BIT] ? tacho_four_wire : 3'h0;
  end
  wire [7:0] ridx = araddr[9:2];
  always_comb
  begin
    rd_word = 8'h00;
    rd_ok = 1'b1;
    if (ridx == `MOCC_IDX_CFG1)
      rd_word = cfg1_r;
    else if (ridx == `MOCC_IDX_TMIN1)
      rd_word = tmin1_r;
    else if (ridx == `MOCC_IDX_LOFS)
      rd_word = lofs_r;
    else if (ridx == `MOCC_IDX_R2OFS)
      rd_word = r2ofs_r;
    else if (ridx == `MOCC_IDX_CFG2)
      rd_word = cfg2_view;
    else if (ridx == `MOCC_IDX_CFG5)
      rd_word = cfg5_r;
    else if (ridx == `MOCC_IDX_CFG4)
      rd_word = cfg4_r;
    else
      rd_ok = 1'b0;
  end
  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdat_r <= 8'h00;
      rresp_r <= `MOCC_RESP_OKAY;
    end
    else if (arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdat_r <= rd_word;
      rresp_r <= rd_ok ? `MOCC_RESP_OKAY : `MOCC_RESP_SLVERR;
    end
    else if (rvalid_r && rready)
      rvalid_r <= 1'b0;
    else if (!rvalid_r)
      arready_r <= 1'b1;
  end
  // slot length latched per slot: an averaging change applies from the next slot
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slot_cnt_r <= 16'h0;
      slot_len_r <= SLOW_LEN;
      chan_r <= mocc_pkg::CH_2V5;
      single_channel_mode_start_r <= 1'b0;
    end
    else if (slot_end)
    begin
      slot_cnt_r <= 16'h0;
      slot_len_r <= len_nxt;
      chan_r <= chan_nxt;
      single_channel_mode_start_r <= 1'b1;
    end
    else
    begin
      slot_cnt_r <= slot_cnt_r + 16'h1;
      single_channel_mode_start_r <= 1'b0;
    end
  end
  // converter steering and offset correction
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      avg_on_r <= 1'b1;
      attenuator_bypass_r <= 4'h0;
      res_r <= 8'h00;
      res_chan_r <= 3'h0;
      res_valid_r <= 1'b0;
    end
    else
    begin
      avg_on_r <= !avg_dis;
      attenuator_bypass_r <= attenuator_bypass_nxt;
      res_valid_r <= single_channel_mode_done;
      if (single_channel_mode_done)
      begin
        res_r <= corr;
        res_chan_r <= chan_r;
      end
    end
  end
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = {24'h000000, rdat_r};
  assign rresp = rresp_r;
  assign single_channel_mode_start = single_channel_mode_start_r;
  assign single_channel_mode_channel = chan_r;
  assign averaging_on = avg_on_r;
  assign attenuator_bypass_off = attenuator_bypass_r;
  assign result = res_r;
  assign result_chan = res_chan_r;
  assign result_valid = res_valid_r;
  // helper: cycles between two slot starts
  logic [15:0] gap_r, glen_r;
  logic armed_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap_r <= 16'h0;
      glen_r <= 16'h0;
      armed_r <= 1'b0;
    end
    else if (single_channel_mode_start_r)
    begin
      gap_r <= 16'h1;
      glen_r <= slot_len_r;
      armed_r <= 1'b1;
    end
    else
      gap_r <= gap_r + 16'h1;
  end
  lock_hold_a: assert property (locked |=> $stable(lofs_r) && $stable(r2ofs_r))
    else $error("offset changed while locked");
  reset_zero_a: assert property (
    $rose(aresetn) |-> lofs_r == 8'h00 && r2ofs_r == 8'h00 && cfg2_r == 8'h00)
    else $error("registers not zero after reset");
  flag_follow_a: assert property (
    cfg2_r[`MOCC_FDET_BIT] |=> flags_r == $past(tacho_four_wire))
    else $error("presence flags do not follow tacho");
  flag_off_a: assert property (
    !cfg2_r[`MOCC_FDET_BIT] ##1 !cfg2_r[`MOCC_FDET_BIT] |-> cfg2_view[3:1] == 3'h0)
    else $error("presence flags set while detect off");
  slot_len_a: assert property (
    single_channel_mode_start_r |-> slot_len_r == ($past(avg_dis) ? FAST_LEN : SLOW_LEN))
    else $error("wrong slot length for averaging mode");
  slot_gap_a: assert property (single_channel_mode_start_r && armed_r |-> gap_r == glen_r)
    else $error("slot spacing differs from slot length");
  attenuator_bypass_all_a: assert property (cfg2_r[`MOCC_ATTENUATOR_BYPASS_BIT] |=> attenuator_bypass_off == 4'hf)
    else $error("bypass bit did not remove all attenuators");
  attenuator_bypass_chan_a: assert property (!cfg2_r[`MOCC_ATTENUATOR_BYPASS_BIT] |=> attenuator_bypass_off == $past(cfg4_r[7:4]))
    else $error("per-channel attenuator control wrong");
  single_keep_a: assert property (
    single_channel_mode_start_r && $past(single) && $past(sel) == $past(chan_r) |-> $stable(chan_r))
    else $error("single mode left its channel");
  single_sel_a: assert property (single_channel_mode_start_r && $past(single) |-> chan_r == $past(sel))
    else $error("single mode channel not from selector");
  seq_step_a: assert property (
    single_channel_mode_start_r && !$past(single) |-> chan_r == 3'($past(chan_r) + 3'h1))
    else $error("normal sequence did not advance");
  local_ofs_a: assert property (
    res_valid_r && res_chan_r == mocc_pkg::CH_LOCAL && $past(range_full)
    |-> res_r == 8'($past(single_channel_mode_raw) + $past(lofs_r)))
    else $error("local offset not applied");
  rem2_ofs_a: assert property (
    res_valid_r && res_chan_r == mocc_pkg::CH_REM2 && $past(range_full)
    |-> res_r == 8'($past(single_channel_mode_raw) + $past(r2ofs_r)))
    else $error("remote two offset not applied");
  half_range_a: assert property (
    res_valid_r && res_chan_r == mocc_pkg::CH_LOCAL && !$past(range_full)
    |-> res_r == 8'($past(single_channel_mode_raw) + {$past(lofs_r[7]), $past(lofs_r[7:1])}))
    else $error("half range offset wrong");
endmodule
`default_nettype wire
